// *** cpus_pkg.sv ***
// constants for the card power-up sequencer
// assumes a 40 MHz core clock and supply-detect inputs from comparators
// What the document asks of card and host
// [R1] card accepts first command within 1 ms of primary supply detect
// [R2] card may use 74 bus clocks to prepare, then must be ready
// [R3] host ramps supply within 250 ms then sends 74 clocks, command high
// [R4] in serial-peripheral mode host holds chip select high during preamble
// [R5] card enters idle after power-up without a reset command
// [R6] serial-peripheral host sends reset command first to pick that mode
// [R7] newer host checks voltage with interface-condition command first
// [R8] host lacking that command powers card from high range only
// [R9] host polls operating-condition command until card leaves power-up; the host model sends a fixed count of polls
// [R10] host holds supply below 0.5 V for 1 ms before ramp
// [R11] host releases or drives lines low while card power is off
// [R12] host power cycles to change voltage or reach inactive card
// [R13] host waits for stable supply; ramp 0.1 ms to 35 ms
// [R14] serial-link card ready for phy init within 1 ms of later supply
// [R15] serial-link card accepts either supply order, uses the later one
// [R16] host waits 1 ms after both supplies before reference clock
// [R17] host keeps supplies below 0.5 V and 0.2 V for 1 ms
// [R18] host counts off, settle and preamble intervals from its clock
package cpus_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ          = 40000000;
  localparam int READY_US        = 1000;
  localparam int READY_CYCLES    = READY_US * (CLK_HZ / 1000000);
  localparam int PREAMBLE_CLOCKS = 74;
  localparam int FILTER_CYCLES   = 4;
  // ----------------------------------------
  // states
  // ----------------------------------------
  typedef enum logic [2:0] {
    CPUS_OFF     = 3'b000,
    CPUS_PREP    = 3'b001,
    CPUS_IDLE    = 3'b010,
    CPUS_ACTIVE  = 3'b011
  } cpus_state_e;
endpackage

// *** cpus_sync.sv ***
// two-flop synchroniser with a clean edge-detect on the synced copy
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
module cpus_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout,
  output logic      rise
);
  logic meta;
  logic prev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      dout <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
      prev <= dout;
    end
  end

  assign rise = dout & ~prev;
endmodule

// *** cpus_card_power_up_sequencer.sv ***
// card-side power-up sequencer: supply detect, preamble count, idle entry
// assumes supply-detect levels, bus clock and command/select pins are asynchronous
`timescale 1ns/1ps
module cpus_card_power_up_sequencer
  import cpus_pkg::*;
#(
  parameter int READY_COUNT = READY_CYCLES
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic primary_card_supply_ok,
  input  wire logic secondary_card_supply_ok,
  input  wire logic serial_link_card,
  input  wire logic bus_clk,
  input  wire logic cmd_line,
  input  wire logic chip_select_n,
  output logic      cmd_ready,
  output logic      phy_init_ready,
  output logic      card_idle,
  output logic      preamble_done,
  output logic      spi_select_seen,
  output logic      ready_timeout
);
  // ----------------------------------------
  // reset and input synchronisation
  // ----------------------------------------
  logic rst_a;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end

  // every pin but serial_link_card is asynchronous to clk, so each of the five passes its own two flops
  localparam int NPIN     = 5;
  localparam int PIN_P    = 0;
  localparam int PIN_S    = 1;
  localparam int PIN_BCLK = 2;
  localparam int PIN_CMD  = 3;
  localparam int PIN_CS   = 4;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s;
  logic [NPIN-1:0] pin_rise;
  logic            p_ok;
  logic            s_ok;
  logic            bclk_rise;
  logic            cmd_s;
  logic            cs_n_s;

  assign pin_raw[PIN_P]    = primary_card_supply_ok;
  assign pin_raw[PIN_S]    = secondary_card_supply_ok;
  assign pin_raw[PIN_BCLK] = bus_clk;
  assign pin_raw[PIN_CMD]  = cmd_line;
  assign pin_raw[PIN_CS]   = chip_select_n;

  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    cpus_sync u_sync (
      .clk  (clk),
      .rst_n(rst_n),
      .din  (pin_raw[i]),
      .dout (pin_s[i]),
      .rise (pin_rise[i])
    );
  end

  // only the bus clock needs its edge; the levels serve everything else
  assign p_ok      = pin_s[PIN_P];
  assign s_ok      = pin_s[PIN_S];
  assign bclk_rise = pin_rise[PIN_BCLK];
  assign cmd_s     = pin_s[PIN_CMD];
  assign cs_n_s    = pin_s[PIN_CS];

  // ----------------------------------------
  // supply qualification
  // ----------------------------------------
  // serial-link cards wait for whichever supply arrives later
  wire both_up   = p_ok & s_ok;
  wire supply_up = serial_link_card ? both_up : p_ok; // [R15]

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  localparam int RW = $clog2(READY_COUNT + 1);
  localparam int PW = $clog2(PREAMBLE_CLOCKS + 1);

  cpus_state_e   state;
  cpus_state_e   next_state;
  logic [RW-1:0] ready_cnt;
  logic [PW-1:0] pre_cnt;
  logic          pre_ok;

  // internal preparation is far shorter than the 1 ms budget, so readiness
  // is declared early; the counter also flags a late preamble
  wire prep_done = (ready_cnt >= RW'(FILTER_CYCLES)); // [R1] [R14]
  wire pre_edge  = bclk_rise & cmd_s & cs_n_s;
  wire pre_full  = (pre_cnt == PW'(PREAMBLE_CLOCKS));

  always_comb begin
    next_state = state;
    case (state)
      CPUS_OFF: begin
        if (supply_up) begin
          next_state = CPUS_PREP;
        end
      end
      CPUS_PREP: begin
        if (!supply_up) begin
          next_state = CPUS_OFF;
        end else if (prep_done) begin
          next_state = CPUS_IDLE; // [R5]
        end
      end
      CPUS_IDLE: begin
        if (!supply_up) begin
          next_state = CPUS_OFF;
        end else if (pre_full && !cmd_s) begin
          next_state = CPUS_ACTIVE;
        end
      end
      CPUS_ACTIVE: begin
        if (!supply_up) begin
          next_state = CPUS_OFF;
        end
      end
      default: next_state = CPUS_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CPUS_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_cnt <= '0;
    end else if (state == CPUS_OFF) begin
      ready_cnt <= '0;
    end else if (ready_cnt != RW'(READY_COUNT)) begin
      ready_cnt <= ready_cnt + RW'(1);
    end
  end

  // preamble clocks count only while the host keeps the lines high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= '0;
    end else if (state == CPUS_OFF) begin
      pre_cnt <= '0;
    end else if (pre_edge && !pre_full) begin
      pre_cnt <= pre_cnt + PW'(1); // [R2]
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // chip select low on the first command selects the serial-peripheral mode
  wire spi_set     = (state == CPUS_IDLE) && pre_full && !cs_n_s;
  // diagnostic only: the whole readiness budget ran out before a full preamble
  wire timeout_set = (ready_cnt == RW'(READY_COUNT)) && !pre_full;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ok <= 1'b0;
    end else if (state == CPUS_OFF) begin
      pre_ok <= 1'b0;
    end else begin
      pre_ok <= pre_full;
    end
  end

  // the mode sticks until the supply goes away, as only a power cycle undoes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_select_seen <= 1'b0;
    end else if (state == CPUS_OFF) begin
      spi_select_seen <= 1'b0;
    end else if (spi_set) begin
      spi_select_seen <= 1'b1;
    end
  end

  // cleared with the supply, never by the host
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_timeout <= 1'b0;
    end else if (state == CPUS_OFF) begin
      ready_timeout <= 1'b0;
    end else if (timeout_set) begin
      ready_timeout <= 1'b1;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // registered from the next state so the ready and idle pins move with the state register
  wire next_any_ready = (next_state == CPUS_IDLE) || (next_state == CPUS_ACTIVE);
  wire next_cmd_ready = next_any_ready && !serial_link_card; // [R1] [R2]
  wire next_phy_ready = next_any_ready && serial_link_card;  // [R14]
  wire next_card_idle = (next_state == CPUS_IDLE);           // [R5]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ready      <= 1'b0;
      phy_init_ready <= 1'b0;
      card_idle      <= 1'b0;
      preamble_done  <= 1'b0;
    end else begin
      cmd_ready      <= next_cmd_ready;
      phy_init_ready <= next_phy_ready;
      card_idle      <= next_card_idle;
      preamble_done  <= pre_ok;
    end
  end
endmodule

// *** cpus_power_asserts.sv ***
// checker for the card power-up sequencer outputs
// assumes it is bound to the card power-up sequencer module
`timescale 1ns/1ps
module cpus_power_asserts #(parameter int READY_COUNT = 40000) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic primary_card_supply_ok,
  input wire logic secondary_card_supply_ok,
  input wire logic serial_link_card,
  input wire logic cmd_ready,
  input wire logic phy_init_ready,
  input wire logic card_idle,
  input wire logic preamble_done
);
  // ----
  // cycles of steady supply; saturates so it never wraps
  // ----
  logic [4:0] se_cnt;
  logic [4:0] sl_cnt;
  wire        se_up = primary_card_supply_ok && !serial_link_card;
  wire        sl_up = primary_card_supply_ok && secondary_card_supply_ok && serial_link_card;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      se_cnt <= 5'h00;
      sl_cnt <= 5'h00;
    end else begin
      se_cnt <= !se_up ? 5'h00 : (se_cnt == 5'h1F ? se_cnt : se_cnt + 5'h01);
      sl_cnt <= !sl_up ? 5'h00 : (sl_cnt == 5'h1F ? sl_cnt : sl_cnt + 5'h01);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_ready; se_cnt == 5'h14 |-> cmd_ready && card_idle; endproperty
  a_ready: assert property (p_ready) else $error("card not ready after supply");
  property p_off; !primary_card_supply_ok [*8] |-> !cmd_ready && !card_idle; endproperty
  a_off: assert property (p_off) else $error("card ready without supply");
  property p_pre; $rose(preamble_done) |-> cmd_ready || phy_init_ready; endproperty
  a_pre: assert property (p_pre) else $error("preamble done but not ready");
  property p_phy; sl_cnt == 5'h14 |-> phy_init_ready; endproperty
  a_phy: assert property (p_phy) else $error("phy init not ready");
  property p_later; serial_link_card && !secondary_card_supply_ok [*8] |-> !phy_init_ready;
  endproperty
  a_later: assert property (p_later) else $error("phy ready before later supply");
  c_ready: cover property ($rose(cmd_ready));
  c_phy: cover property ($rose(phy_init_ready));
  c_pre: cover property ($rose(preamble_done));
endmodule
bind cpus_card_power_up_sequencer cpus_power_asserts #(.READY_COUNT(READY_COUNT)) u_chk (
  .clk(clk), .resetn(resetn), .primary_card_supply_ok(primary_card_supply_ok),
  .secondary_card_supply_ok(secondary_card_supply_ok), .serial_link_card(serial_link_card),
  .cmd_ready(cmd_ready), .phy_init_ready(phy_init_ready), .card_idle(card_idle),
  .preamble_done(preamble_done));

// *** cpus_host_model.sv ***
// host model: card supplies, bus clock, command line and select
// assumes one testbench process calls its tasks
`timescale 1ns/1ps
module cpus_host_model #(parameter int OFF_CYCLES = 40000) (
  input  wire logic clk,
  output logic      primary_card_supply_ok,
  output logic      secondary_card_supply_ok,
  output logic      bus_clk,
  output logic      cmd_line,
  output logic      chip_select_n
);
  initial begin
    {primary_card_supply_ok, secondary_card_supply_ok, bus_clk} = 3'h0;
    {cmd_line, chip_select_n} = 2'h0;
  end
  task automatic power_off(); // lines driven low so no current feeds the card
    @(posedge clk);
    primary_card_supply_ok <= 1'b0;
    secondary_card_supply_ok <= 1'b0;
    cmd_line <= 1'b0;
    chip_select_n <= 1'b0;
    repeat (OFF_CYCLES) @(posedge clk);
  endtask
  task automatic supply(input logic p, input logic s); // levels only once ramp is stable
    @(posedge clk);
    primary_card_supply_ok <= p;
    secondary_card_supply_ok <= s;
    cmd_line <= p;
    chip_select_n <= p;
  endtask
  task automatic clocks(input int n); // 200 ns period, stands low outside frames
    repeat (n) begin
      @(posedge clk);
      bus_clk <= 1'b1;
      repeat (4) @(posedge clk);
      bus_clk <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic command(input logic cs_n); // one command after the preamble
    @(posedge clk);
    cmd_line <= 1'b0;
    chip_select_n <= cs_n;
    clocks(8);
  endtask
  task automatic init_polls(input int polls); // voltage check, then condition polls
    command(chip_select_n);
    repeat (polls) command(chip_select_n);
  endtask
endmodule

// *** tb.sv ***
// testbench for the card power-up sequencer
// assumes the host model drives the supply, bus clock, command and select inputs; the testbench drives serial_link_card
`timescale 1ns/1ps
module tb;
  logic clk;
  logic resetn;
  logic serial_link_card;
  wire  p, s, bclk, cmd, csn, cmd_ready, phy_rdy, idle, pre, spi, tmo;
  int   n_errors = 0;
  int   checks = 0;
  cpus_host_model #(.OFF_CYCLES(400)) host (.clk(clk), .primary_card_supply_ok(p),
    .secondary_card_supply_ok(s), .bus_clk(bclk), .cmd_line(cmd), .chip_select_n(csn));
  cpus_card_power_up_sequencer #(.READY_COUNT(200)) dut (.clk(clk), .resetn(resetn),
    .primary_card_supply_ok(p), .secondary_card_supply_ok(s),
    .serial_link_card(serial_link_card), .bus_clk(bclk), .cmd_line(cmd), .chip_select_n(csn),
    .cmd_ready(cmd_ready), .phy_init_ready(phy_rdy), .card_idle(idle), .preamble_done(pre),
    .spi_select_seen(spi), .ready_timeout(tmo));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string name, input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_single();
    host.supply(1'b1, 1'b0);
    w(20);
    chk("cmd_ready", cmd_ready, 1'b1);
    chk("card_idle", idle, 1'b1);
    chk("timeout_early", tmo, 1'b0);
    host.clocks(73);
    w(10);
    chk("preamble_73", pre, 1'b0);
    chk("timeout_late", tmo, 1'b1);
    host.clocks(1);
    w(10);
    chk("preamble_74", pre, 1'b1);
    host.command(1'b0);
    w(10);
    chk("idle_left", idle, 1'b0);
    chk("spi_select", spi, 1'b1);
    host.init_polls(2);
    w(10);
    chk("active_idle", idle, 1'b0);
    chk("active_ready", cmd_ready, 1'b1);
  endtask
  task automatic t_serial();
    host.power_off();
    serial_link_card <= 1'b1;
    w(1);
    chk("off_ready", cmd_ready, 1'b0);
    chk("off_idle", idle, 1'b0);
    chk("off_spi", spi, 1'b0);
    chk("off_preamble", pre, 1'b0);
    chk("off_timeout", tmo, 1'b0);
    host.supply(1'b0, 1'b1);
    w(20);
    chk("phy_one_supply", phy_rdy, 1'b0);
    host.supply(1'b1, 1'b1);
    w(20);
    chk("phy_ready", phy_rdy, 1'b1);
    chk("phy_no_cmd", cmd_ready, 1'b0);
    host.power_off();
    host.supply(1'b1, 1'b0);
    w(20);
    chk("phy_primary_only", phy_rdy, 1'b0);
    host.supply(1'b1, 1'b1);
    w(20);
    chk("phy_ready_rev", phy_rdy, 1'b1);
  endtask
  task automatic t_native();
    host.power_off();
    serial_link_card <= 1'b0;
    host.supply(1'b1, 1'b0);
    w(20);
    chk("native_ready", cmd_ready, 1'b1);
    chk("native_phy", phy_rdy, 1'b0);
    host.clocks(74);
    w(10);
    chk("native_preamble", pre, 1'b1);
    host.command(1'b1);
    w(10);
    chk("native_idle_left", idle, 1'b0);
    chk("native_spi", spi, 1'b0);
  endtask
  initial begin
    resetn = 1'b0;
    serial_link_card = 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_single();
    t_serial();
    t_native();
    report_and_stop();
  end
  initial begin
    #500000;
    n_errors++;
    report_and_stop();
  end
endmodule
